// file: src/uim_core.sv
// Interrupt priority, interrupt enable, modem control and status, loopback,
// scratch storage and FIFO-mode interrupt timing of a serial transceiver.
// Assumes the shifters, FIFOs and line status logic sit outside on ref_clk_i.
//
// What this block does
// - Identification code stays frozen while the CPU reads it.
// - Bit 0 low means pending; bits 1 and 2 give top source.
// - Bit 3 marks timeout in FIFO mode only; bits 4, 5 read zero.
// - Bits 6 and 7 follow the FIFO enable bit.
// - Disabled sources never show or interrupt; status still updates.
// - Enable bits gate rx data, tx empty, line, modem; rest zero.
// - Modem control bits 0 to 3 drive their pins inverted.
// - Loopback holds serial out high and routes transmit into receive.
// - Loopback replaces modem inputs by control bits; pins go high.
// - Loopback modem interrupts come from control bits, still gated.
// - Modem control bits 5 to 7 read zero.
// - Change flags set on input change, clear on status read.
// - Flags for CTS, DSR, DCD any change; ring on trailing edge.
// - Any change flag raises a modem status interrupt.
// - Status high bits are inverted inputs, or control bits in loopback.
// - Eight-bit scratch register stores CPU data, affects nothing.
// - FIFO rx data interrupt follows occupancy against trigger level.
// - Line status beats rx data; timeout sits below rx data, above tx FIFO.
// - In FIFO mode data ready follows a non-empty receive FIFO.
// - Timeout after more than four character times of inactivity.
// - Timer restarts on received character or CPU FIFO read.
// - Tx FIFO empty interrupt clears on data write or INTERRUPT_IDENTIFICATION read.
// - Empty indication delayed unless two bytes held or mode toggled.
// - FIFO enable activates FIFOs; any mode change empties both.
// - Trigger field selects 1, 4, 8 or 14 bytes.
// - Priority: line status, rx data, tx empty, modem status.

`timescale 1ns/1ps

module uim_core #(
  parameter int LEVEL_W = 5
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   arst_n_i,
  input  wire logic                   ce_i,
  input  wire logic [4:0]             address_i,
  input  wire logic                   read_i,
  input  wire logic                   write_i,
  input  wire logic [31:0]            writedata_i,
  input  wire logic [3:0]             byteenable_i,
  output logic      [31:0]            readdata_o,
  output logic                        waitrequest_o,
  input  wire uim_pkg::uim_modem_in_s modem_in_i,
  output uim_pkg::uim_modem_out_s     modem_out_o,
  input  wire logic                   serial_in_pin_i,
  output logic                        serial_out_pin_o,
  input  wire logic                   rclk_i,
  input  wire logic                   tx_shift_i,
  output logic                        rx_serial_o,
  input  wire logic [3:0]             char_bits_i,
  input  wire logic                   line_status_err_i,
  input  wire logic                   rx_data_ready_i,
  input  wire logic [LEVEL_W-1:0]     rx_fifo_level_i,
  input  wire logic                   rx_char_i,
  input  wire logic                   rx_fifo_read_i,
  input  wire logic                   tx_holding_empty_i,
  input  wire logic [LEVEL_W-1:0]     tx_fifo_level_i,
  input  wire logic                   tx_write_i,
  output logic                        fifo_enable_bit_o,
  output logic                        rx_fifo_clear_o,
  output logic                        tx_fifo_clear_o,
  output logic                        data_ready_bit_o,
  output logic                        tx_holding_empty_o,
  output logic                        interrupt_output_o
);

  // ==========================================================================
  // Helpers
  function automatic logic [9:0] char_ticks(input logic [3:0] bits);
    char_ticks = 10'(bits) * uim_pkg::TICKS_PER_BIT;
  endfunction : char_ticks

  function automatic logic [LEVEL_W-1:0] trig_bytes(input logic [1:0] code);
    case (code)
      2'h0:    trig_bytes = LEVEL_W'(1);
      2'h1:    trig_bytes = LEVEL_W'(4);
      2'h2:    trig_bytes = LEVEL_W'(8);
      default: trig_bytes = LEVEL_W'(14);
    endcase
  endfunction : trig_bytes

  // ==========================================================================
  // State
  uim_pkg::uim_state_s st_reg;
  uim_pkg::uim_state_s st_next;

  logic       req;
  logic       go;
  logic       accept;
  logic       wr_ok;
  logic       loop_on;
  logic [3:0] msr_now;
  logic [3:0] msr_set;
  logic [9:0] to_limit;
  logic [9:0] tx_delay;
  logic       tick;
  logic       timeout;
  logic       src_ls;
  logic       src_rd;
  logic       src_to;
  logic       src_th;
  logic       src_ms;
  logic [3:0] code;
  logic [7:0] rd_mux;
  logic       fcr_en;
  logic       tx_empty_raw;
  logic       tx_holding_empty_clr;

  assign req     = read_i | write_i;
  assign go      = req & ~st_reg.ack;
  assign accept  = req & st_reg.ack;
  assign wr_ok   = accept & write_i & byteenable_i[0];
  assign loop_on = st_reg.modem_control[uim_pkg::MCR_LOOP];
  assign tick    = st_reg.rclk_s2 & ~st_reg.rclk_s3;
  assign fcr_en  = writedata_i[uim_pkg::FCR_EN];

  assign to_limit = uim_pkg::TIMEOUT_CHARS * char_ticks(char_bits_i);
  assign tx_delay = char_ticks(char_bits_i) - uim_pkg::TICKS_PER_BIT;
  assign timeout  = st_reg.to_cnt > to_limit;

  // Status high bits in {dcd, ri, dsr, cts} order.
  assign msr_now = loop_on ? {st_reg.modem_control[uim_pkg::MCR_OUT2],
                              st_reg.modem_control[uim_pkg::MCR_OUT1],
                              st_reg.modem_control[uim_pkg::MCR_DTR],
                              st_reg.modem_control[uim_pkg::MCR_RTS]}
                           : ~st_reg.modem_s2;

  assign msr_set = (st_reg.prime != uim_pkg::PRIME_DONE) ? 4'h0 :
                   {st_reg.msr_prev[3] ^ msr_now[3],
                    st_reg.msr_prev[2] & ~msr_now[2],
                    st_reg.msr_prev[1] ^ msr_now[1],
                    st_reg.msr_prev[0] ^ msr_now[0]};

  // ==========================================================================
  // Interrupt sources and priority
  assign src_ls = st_reg.interrupt_enable[uim_pkg::IER_LS] & line_status_err_i;
  assign src_rd = st_reg.interrupt_enable[uim_pkg::IER_RX] &
                  (st_reg.fifo_en ?
                   (rx_fifo_level_i >= trig_bytes(st_reg.trig))
                   : rx_data_ready_i);
  assign src_to = st_reg.interrupt_enable[uim_pkg::IER_RX] & st_reg.fifo_en & timeout;
  assign src_th = st_reg.interrupt_enable[uim_pkg::IER_TX] & st_reg.tx_holding_empty_pend;
  assign src_ms = st_reg.interrupt_enable[uim_pkg::IER_MS] & (|st_reg.delta);

  always_comb begin
    if (src_ls) begin
      code = uim_pkg::IIR_LINE;
    end else if (src_rd) begin
      code = uim_pkg::IIR_RXDATA;
    end else if (src_to) begin
      code = uim_pkg::IIR_TIMEOUT;
    end else if (src_th) begin
      code = uim_pkg::IIR_TX_HOLDING_EMPTY;
    end else if (src_ms) begin
      code = uim_pkg::IIR_MODEM;
    end else begin
      code = uim_pkg::IIR_NONE;
    end
  end

  always_comb begin
    case (address_i)
      uim_pkg::ADDR_IER:     rd_mux = {4'h0, st_reg.interrupt_enable};
      uim_pkg::ADDR_IIR_FCR: rd_mux = {st_reg.fifo_en, st_reg.fifo_en,
                                       2'h0, st_reg.interrupt_identification};
      uim_pkg::ADDR_MCR:     rd_mux = {3'h0, st_reg.modem_control};
      uim_pkg::ADDR_MSR:     rd_mux = {msr_now, st_reg.delta};
      uim_pkg::ADDR_SCR:     rd_mux = st_reg.scratchpad;
      default:               rd_mux = 8'h00;
    endcase
  end

  assign tx_empty_raw = tx_fifo_level_i == '0;
  assign tx_holding_empty_clr     = tx_write_i |
                        (accept & read_i &
                         address_i == uim_pkg::ADDR_IIR_FCR &
                         st_reg.interrupt_identification == uim_pkg::IIR_TX_HOLDING_EMPTY);

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    if (ce_i) begin
      st_next.rx_clr = 1'b0;
      st_next.tx_clr = 1'b0;

      // Input synchronisers.
      st_next.modem_s1 = modem_in_i;
      st_next.modem_s2 = st_reg.modem_s1;
      st_next.sin_s1   = serial_in_pin_i;
      st_next.sin_s2   = st_reg.sin_s1;
      st_next.rclk_s1  = rclk_i;
      st_next.rclk_s2  = st_reg.rclk_s1;
      st_next.rclk_s3  = st_reg.rclk_s2;
      if (st_reg.prime != uim_pkg::PRIME_DONE) begin
        st_next.prime = st_reg.prime + 2'h1;
      end

      // Bus slave: one wait cycle, side effects at the accepting edge.
      st_next.ack = go;
      if (go) begin
        st_next.rdata = rd_mux;
      end
      if (!(read_i && address_i == uim_pkg::ADDR_IIR_FCR)) begin
        st_next.interrupt_identification = code;
      end
      st_next.irq = src_ls | src_rd | src_to | src_th | src_ms;

      // Change flags: a new change wins over the read that clears them.
      st_next.msr_prev = msr_now;
      st_next.delta = ((accept && read_i && address_i == uim_pkg::ADDR_MSR)
                       ? 4'h0 : st_reg.delta) | msr_set;

      if (wr_ok) begin
        case (address_i)
          uim_pkg::ADDR_IER: st_next.interrupt_enable = writedata_i[3:0];
          uim_pkg::ADDR_MCR: st_next.modem_control = writedata_i[4:0];
          uim_pkg::ADDR_SCR: st_next.scratchpad = writedata_i[7:0];
          uim_pkg::ADDR_IIR_FCR: begin
            if (fcr_en != st_reg.fifo_en) begin
              st_next.fifo_en = fcr_en;
              st_next.rx_clr  = 1'b1;
              st_next.tx_clr  = 1'b1;
              st_next.first   = 1'b1;
            end
            if (fcr_en) begin
              st_next.rx_clr = st_next.rx_clr | writedata_i[uim_pkg::FCR_RXCLR];
              st_next.tx_clr = st_next.tx_clr | writedata_i[uim_pkg::FCR_TXCLR];
              st_next.trig   = writedata_i[uim_pkg::FCR_TRIG_LSB +: 2];
            end
          end
          default: begin
          end
        endcase
      end

      // Receive timeout timer.
      if (!st_reg.fifo_en || rx_fifo_level_i == '0 ||
          rx_char_i || rx_fifo_read_i) begin
        st_next.to_cnt = 10'h000;
      end else if (tick && st_reg.to_cnt <= to_limit) begin
        st_next.to_cnt = st_reg.to_cnt + 10'h001;
      end

      st_next.dr = st_reg.fifo_en ? (rx_fifo_level_i != '0)
                                  : rx_data_ready_i;

      // Transmit empty indication.
      if (!st_reg.fifo_en) begin
        st_next.tx_holding_empty_ind = tx_holding_empty_i;
        st_next.txd_act  = 1'b0;
      end else if (!tx_empty_raw) begin
        st_next.tx_holding_empty_ind = 1'b0;
        st_next.txd_act  = 1'b0;
        if (tx_fifo_level_i >= LEVEL_W'(2)) begin
          st_next.two_held = 1'b1;
        end
      end else if (!st_reg.tx_holding_empty_ind && !st_reg.txd_act) begin
        if (st_reg.two_held || st_reg.first) begin
          st_next.tx_holding_empty_ind = 1'b1;
          st_next.two_held = 1'b0;
          st_next.first    = 1'b0;
        end else begin
          st_next.txd_act = 1'b1;
          st_next.txd_cnt = tx_delay;
        end
      end else if (st_reg.txd_act && tick) begin
        if (st_reg.txd_cnt == 10'h000) begin
          st_next.tx_holding_empty_ind = 1'b1;
          st_next.txd_act  = 1'b0;
        end else begin
          st_next.txd_cnt = st_reg.txd_cnt - 10'h001;
        end
      end
      st_next.tx_holding_empty_pend = (st_reg.tx_holding_empty_pend & ~tx_holding_empty_clr) |
                          (st_next.tx_holding_empty_ind & ~st_reg.tx_holding_empty_ind);

      // Loopback serial routing.
      st_next.serial_out_pin = loop_on | tx_shift_i;
      st_next.rxin = loop_on ? tx_shift_i : st_reg.sin_s2;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg      <= '0;
      st_reg.interrupt_identification  <= uim_pkg::IIR_NONE;
      st_reg.interrupt_enable  <= uim_pkg::IER_RST;
      st_reg.modem_control  <= uim_pkg::MCR_RST;
      st_reg.scratchpad  <= uim_pkg::SCR_RST;
      st_reg.serial_out_pin <= 1'b1;
      st_reg.rxin <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign readdata_o         = {24'h000000, st_reg.rdata};
  assign waitrequest_o      = go;
  assign modem_out_o        = loop_on ? 4'hF : ~st_reg.modem_control[3:0];
  assign serial_out_pin_o   = st_reg.serial_out_pin;
  assign rx_serial_o        = st_reg.rxin;
  assign fifo_enable_bit_o  = st_reg.fifo_en;
  assign rx_fifo_clear_o    = st_reg.rx_clr;
  assign tx_fifo_clear_o    = st_reg.tx_clr;
  assign data_ready_bit_o   = st_reg.dr;
  assign tx_holding_empty_o = st_reg.tx_holding_empty_ind;
  assign interrupt_output_o = st_reg.irq;

endmodule : uim_core

// file: src/uim_pkg.sv
// Shared constants and types for the interrupt and modem control block.
// Assumes a byte-wide register view carried in the low lane of a 32-bit bus.
package uim_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [4:0] ADDR_IER     = 5'h04;
  localparam logic [4:0] ADDR_IIR_FCR = 5'h08;
  localparam logic [4:0] ADDR_MCR     = 5'h10;
  localparam logic [4:0] ADDR_MSR     = 5'h18;
  localparam logic [4:0] ADDR_SCR     = 5'h1C;

  // ==========================================================================
  // Identification codes, bits 3 to 0
  localparam logic [3:0] IIR_NONE     = 4'h1;
  localparam logic [3:0] IIR_LINE     = 4'h6;
  localparam logic [3:0] IIR_RXDATA   = 4'h4;
  localparam logic [3:0] IIR_TIMEOUT  = 4'hC;
  localparam logic [3:0] IIR_TX_HOLDING_EMPTY     = 4'h2;
  localparam logic [3:0] IIR_MODEM    = 4'h0;

  // ==========================================================================
  // Field positions
  localparam int IER_RX       = 0;
  localparam int IER_TX       = 1;
  localparam int IER_LS       = 2;
  localparam int IER_MS       = 3;
  localparam int MCR_DTR      = 0;
  localparam int MCR_RTS      = 1;
  localparam int MCR_OUT1     = 2;
  localparam int MCR_OUT2     = 3;
  localparam int MCR_LOOP     = 4;
  localparam int FCR_EN       = 0;
  localparam int FCR_RXCLR    = 1;
  localparam int FCR_TXCLR    = 2;
  localparam int FCR_TRIG_LSB = 6;

  // ==========================================================================
  // Reset values and counts
  localparam logic [3:0] IER_RST      = 4'h0;
  localparam logic [4:0] MCR_RST      = 5'h00;
  localparam logic [7:0] SCR_RST      = 8'h00;
  localparam logic [1:0] PRIME_DONE   = 2'h3;
  localparam logic [9:0] TIMEOUT_CHARS = 10'h004;
  localparam logic [9:0] TICKS_PER_BIT = 10'h010;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } uim_modem_in_s;

  typedef struct packed {
    logic out2_n;
    logic out1_n;
    logic rts_n;
    logic dtr_n;
  } uim_modem_out_s;

  typedef struct packed {
    logic        ack;
    logic [7:0]  rdata;
    logic [3:0]  interrupt_enable;
    logic [4:0]  modem_control;
    logic [7:0]  scratchpad;
    logic        fifo_en;
    logic [1:0]  trig;
    logic [3:0]  interrupt_identification;
    logic        irq;
    logic [3:0]  delta;
    logic [3:0]  msr_prev;
    logic [1:0]  prime;
    logic [3:0]  modem_s1;
    logic [3:0]  modem_s2;
    logic        sin_s1;
    logic        sin_s2;
    logic        rclk_s1;
    logic        rclk_s2;
    logic        rclk_s3;
    logic [9:0]  to_cnt;
    logic        tx_holding_empty_ind;
    logic        tx_holding_empty_pend;
    logic        two_held;
    logic        first;
    logic        txd_act;
    logic [9:0]  txd_cnt;
    logic        rx_clr;
    logic        tx_clr;
    logic        dr;
    logic        serial_out_pin;
    logic        rxin;
  } uim_state_s;

endpackage : uim_pkg

// file: verification/uim_core_props.sv
// Checker of register, pin and FIFO status relations of the core.
// Assumes it is bound into uim_core and sees only the core's ports.
`timescale 1ns/1ps

module uim_core_props #(
  parameter int LEVEL_W = 5
) (
  input wire logic                    ref_clk_i,
  input wire logic                    arst_n_i,
  input wire logic [4:0]              address_i,
  input wire logic                    read_i,
  input wire logic                    write_i,
  input wire logic [31:0]             writedata_i,
  input wire logic [3:0]              byteenable_i,
  input wire logic [31:0]             readdata_o,
  input wire logic                    waitrequest_o,
  input wire uim_pkg::uim_modem_out_s modem_out_o,
  input wire logic                    serial_out_pin_o,
  input wire logic [LEVEL_W-1:0]      rx_fifo_level_i,
  input wire logic                    fifo_enable_bit_o,
  input wire logic                    rx_fifo_clear_o,
  input wire logic                    tx_fifo_clear_o,
  input wire logic                    data_ready_bit_o,
  input wire logic                    interrupt_output_o
);
  // ==========================================================================
  // Shadows of the control and enable registers.
  logic [4:0] ctl_reg;
  logic [3:0] ena_reg;
  logic [3:0] quiet_reg;
  logic       acc_wr;
  logic       acc_rd;
  assign acc_wr = write_i & ~waitrequest_o & byteenable_i[0];
  assign acc_rd = read_i & ~waitrequest_o;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_reg   <= 5'h00;
      ena_reg   <= 4'h0;
      quiet_reg <= 4'h0;
    end else begin
      if (acc_wr && address_i == uim_pkg::ADDR_MCR) begin
        ctl_reg <= writedata_i[4:0];
      end
      if (acc_wr && address_i == uim_pkg::ADDR_IER) begin
        ena_reg <= writedata_i[3:0];
      end
      quiet_reg <= acc_wr ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hF};
    end
  end

  // ==========================================================================
  // Properties.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_pins;
    4'(modem_out_o) == (ctl_reg[4] ? 4'hF : ~ctl_reg[3:0]);
  endproperty
  a_pins: assert property (p_pins)
    else $error("modem pins mismatch");
  property p_loop_out;
    ctl_reg[4] && $past(ctl_reg[4]) |-> serial_out_pin_o;
  endproperty
  a_loop_out: assert property (p_loop_out)
    else $error("serial out not marking");
  property p_id_bits;
    acc_rd && address_i == uim_pkg::ADDR_IIR_FCR |-> readdata_o[5:4] == 2'h0
      && readdata_o[7:6] == {2{fifo_enable_bit_o}};
  endproperty
  a_id_bits: assert property (p_id_bits)
    else $error("identification upper bits wrong");
  property p_ena_read;
    acc_rd && address_i == uim_pkg::ADDR_IER |-> readdata_o[7:0] == {4'h0, ena_reg};
  endproperty
  a_ena_read: assert property (p_ena_read)
    else $error("enable readback wrong");
  property p_ctl_read;
    acc_rd && address_i == uim_pkg::ADDR_MCR |-> readdata_o[7:0] == {3'h0, ctl_reg};
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control readback wrong");
  property p_loop_sts;
    acc_rd && address_i == uim_pkg::ADDR_MSR && ctl_reg[4] && quiet_reg > 4'h7
      |-> readdata_o[7:4] == {ctl_reg[3], ctl_reg[2], ctl_reg[0], ctl_reg[1]};
  endproperty
  a_loop_sts: assert property (p_loop_sts)
    else $error("loopback status wrong");
  property p_clear;
    $changed(fifo_enable_bit_o) |-> ##[0:2] (rx_fifo_clear_o && tx_fifo_clear_o);
  endproperty
  a_clear: assert property (p_clear)
    else $error("mode change did not clear");
  property p_ready;
    fifo_enable_bit_o && $past(fifo_enable_bit_o)
      |-> data_ready_bit_o == ($past(rx_fifo_level_i) != '0);
  endproperty
  a_ready: assert property (p_ready)
    else $error("data ready wrong");
  property p_quiet_irq;
    quiet_reg > 4'h2 && ena_reg == 4'h0 |-> !interrupt_output_o;
  endproperty
  a_quiet_irq: assert property (p_quiet_irq)
    else $error("interrupt with sources disabled");
  c_loop: cover property (ctl_reg[4] && acc_rd);
  c_fifo: cover property ($rose(fifo_enable_bit_o));
  c_irq: cover property ($rose(interrupt_output_o));
endmodule : uim_core_props

bind uim_core uim_core_props #(.LEVEL_W(LEVEL_W)) uim_core_props_i (
  .ref_clk_i, .arst_n_i, .address_i, .read_i, .write_i, .writedata_i,
  .byteenable_i, .readdata_o, .waitrequest_o, .modem_out_o, .serial_out_pin_o,
  .rx_fifo_level_i, .fifo_enable_bit_o, .rx_fifo_clear_o, .tx_fifo_clear_o,
  .data_ready_bit_o, .interrupt_output_o);

// file: verification/uim_modem_peer.sv
// Model of the modem handshake lines facing the core.
// Assumes the bench names the wanted pin levels; pins idle inactive high.
`timescale 1ns/1ps

module uim_modem_peer (
  input  wire logic              ref_clk_i,
  input  wire logic [3:0]        want_i,
  output uim_pkg::uim_modem_in_s modem_in_o
);
  // ==========================================================================
  // Pins change just after a clock edge and hold until told otherwise.
  initial modem_in_o = 4'hF;
  always @(posedge ref_clk_i) begin
    modem_in_o <= want_i;
  end
endmodule : uim_modem_peer

// file: verification/tb_uim_core.sv
// Self-checking bench of the interrupt and modem control core.
// Assumes the core's one-wait-state bus and two-flop input synchronisers.
`timescale 1ns/1ps

module tb_uim_core;
  logic                    ref_clk_i = 1'b0;
  logic                    arst_n_i = 1'b0;
  logic [4:0]              address_i = 5'h00;
  logic                    read_i = 1'b0;
  logic                    write_i = 1'b0;
  logic [31:0]             writedata_i = 32'h0;
  logic [31:0]             readdata_o;
  logic                    waitrequest_o;
  logic [3:0]              pins = 4'hF;
  uim_pkg::uim_modem_in_s  modem_in_i;
  uim_pkg::uim_modem_out_s modem_out_o;
  logic                    serial_out_pin_o, rx_serial_o, rclk_i = 1'b0;
  logic                    tx_shift_i = 1'b1, line_status_err_i = 1'b0;
  logic                    rx_data_ready_i = 1'b0, rx_char_i = 1'b0;
  logic                    rx_fifo_read_i = 1'b0, tx_holding_empty_i = 1'b0;
  logic [4:0]              rx_fifo_level_i = 5'h00, tx_fifo_level_i = 5'h00;
  logic                    fifo_enable_bit_o, data_ready_bit_o;
  logic                    interrupt_output_o, tx_holding_empty_o;
  logic                    tx_write_i = 1'b0;
  int                      fails = 0, n_tests = 0, cyc = 0;

  // ==========================================================================
  // Clock, receiver tick, timeout, instances.
  always #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    rclk_i <= ~rclk_i;
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fails = fails + 1;
      finish_test();
    end
  end
  uim_modem_peer uim_modem_peer_i (.ref_clk_i, .want_i(pins),
    .modem_in_o(modem_in_i));
  uim_core #(.LEVEL_W(5)) uim_core_i (.ref_clk_i, .arst_n_i, .ce_i(1'b1),
    .address_i, .read_i, .write_i, .writedata_i, .byteenable_i(4'hF),
    .readdata_o, .waitrequest_o, .modem_in_i, .modem_out_o,
    .serial_in_pin_i(1'b1), .serial_out_pin_o, .rclk_i, .tx_shift_i,
    .rx_serial_o, .char_bits_i(4'h4), .line_status_err_i, .rx_data_ready_i,
    .rx_fifo_level_i, .rx_char_i, .rx_fifo_read_i, .tx_holding_empty_i,
    .tx_fifo_level_i, .tx_write_i, .fifo_enable_bit_o,
    .rx_fifo_clear_o(), .tx_fifo_clear_o(), .data_ready_bit_o,
    .tx_holding_empty_o, .interrupt_output_o);

  // ==========================================================================
  // Bus, compare and closing tasks.
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge ref_clk_i);
    write_i <= w;
    read_i <= !w;
    address_i <= a;
    writedata_i <= {24'h0, d};
    do begin
      @(posedge ref_clk_i);
    end while (waitrequest_o);
    q = readdata_o[7:0];
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string nm, input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : idle
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Scenarios.
  task t_reset;
    rd("ena", uim_pkg::ADDR_IER, 8'h00);
    rd("ctl", uim_pkg::ADDR_MCR, 8'h00);
    rd("sts", uim_pkg::ADDR_MSR, 8'h00);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'h01);
    wr(uim_pkg::ADDR_SCR, 8'hA5);
    rd("scr", uim_pkg::ADDR_SCR, 8'hA5);
    wr(uim_pkg::ADDR_SCR, 8'h5A);
    rd("scr", uim_pkg::ADDR_SCR, 8'h5A);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'h01);
  endtask : t_reset
  task t_loop;
    wr(uim_pkg::ADDR_IER, 8'hF8);
    rd("ena", uim_pkg::ADDR_IER, 8'h08);
    wr(uim_pkg::ADDR_MCR, 8'hEA);
    rd("ctl", uim_pkg::ADDR_MCR, 8'h0A);
    chk("pins", 8'h05, {4'h0, modem_out_o});
    wr(uim_pkg::ADDR_MCR, 8'h1A);
    tx_shift_i <= 1'b0;
    idle(6);
    chk("pins", 8'h0F, {4'h0, modem_out_o});
    chk("out", 8'h01, {7'h0, serial_out_pin_o});
    chk("loopin", 8'h00, {7'h0, rx_serial_o});
    chk("irq", 8'h01, {7'h0, interrupt_output_o});
    tx_shift_i <= 1'b1;
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'h00);
    rd("sts", uim_pkg::ADDR_MSR, 8'h99);
    rd("sts", uim_pkg::ADDR_MSR, 8'h90);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'h01);
    wr(uim_pkg::ADDR_MCR, 8'h1E);
    idle(6);
    rd("sts", uim_pkg::ADDR_MSR, 8'hD0);
    wr(uim_pkg::ADDR_MCR, 8'h1A);
    idle(6);
    rd("sts", uim_pkg::ADDR_MSR, 8'h94);
    wr(uim_pkg::ADDR_MCR, 8'h00);
    idle(6);
    rd("sts", uim_pkg::ADDR_MSR, 8'h09);
  endtask : t_loop
  task t_pins;
    pins <= 4'hE;
    idle(6);
    rd("sts", uim_pkg::ADDR_MSR, 8'h11);
    pins <= 4'hA;
    idle(6);
    pins <= 4'hE;
    idle(6);
    rd("sts", uim_pkg::ADDR_MSR, 8'h14);
    wr(uim_pkg::ADDR_IER, 8'h00);
    pins <= 4'hC;
    idle(6);
    chk("irq", 8'h00, {7'h0, interrupt_output_o});
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'h01);
    rd("sts", uim_pkg::ADDR_MSR, 8'h32);
  endtask : t_pins
  task t_prio;
    wr(uim_pkg::ADDR_IER, 8'h0F);
    line_status_err_i <= 1'b1;
    rx_data_ready_i <= 1'b1;
    tx_holding_empty_i <= 1'b1;
    pins <= 4'hF;
    idle(6);
    chk("irq", 8'h01, {7'h0, interrupt_output_o});
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'h06);
    line_status_err_i <= 1'b0;
    idle(3);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'h04);
    rx_data_ready_i <= 1'b0;
    idle(3);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'h02);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'h00);
    rd("sts", uim_pkg::ADDR_MSR, 8'h03);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'h01);
    tx_holding_empty_i <= 1'b0;
    chk("irq", 8'h00, {7'h0, interrupt_output_o});
  endtask : t_prio
  task t_fifo;
    logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
    wr(uim_pkg::ADDR_IER, 8'h01);
    wr(uim_pkg::ADDR_IIR_FCR, 8'h01);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'hC1);
    for (int i = 0; i < 4; i++) begin
      wr(uim_pkg::ADDR_IIR_FCR, {i[1:0], 6'h01});
      rx_fifo_level_i <= lv[i] - 5'h01;
      idle(4);
      rd("id", uim_pkg::ADDR_IIR_FCR, 8'hC1);
      chk("ready", {7'h0, i != 0}, {7'h0, data_ready_bit_o});
      rx_fifo_level_i <= lv[i];
      idle(4);
      rd("id", uim_pkg::ADDR_IIR_FCR, 8'hC4);
    end
    rx_fifo_level_i <= 5'h01;
    rx_char_i <= 1'b1;
    idle(1);
    rx_char_i <= 1'b0;
    idle(300);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'hC1);
    idle(500);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'hCC);
    rx_fifo_read_i <= 1'b1;
    idle(1);
    rx_fifo_read_i <= 1'b0;
    idle(4);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'hC1);
    rx_fifo_level_i <= 5'h00;
    wr(uim_pkg::ADDR_IER, 8'h03);
    for (int n = 1; n < 3; n++) begin
      rd("id", uim_pkg::ADDR_IIR_FCR, 8'hC2);
      tx_fifo_level_i <= 5'(n);
      tx_write_i <= 1'b1;
      idle(1);
      tx_write_i <= 1'b0;
      tx_fifo_level_i <= 5'h00;
      idle(60);
      chk("empty", {7'h0, n == 2}, {7'h0, tx_holding_empty_o});
      idle(60);
    end
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'hC2);
    wr(uim_pkg::ADDR_IIR_FCR, 8'h00);
    rd("id", uim_pkg::ADDR_IIR_FCR, 8'h01);
  endtask : t_fifo

  initial begin
    idle(2);
    arst_n_i <= 1'b1;
    t_reset();
    t_loop();
    t_pins();
    t_prio();
    t_fifo();
    finish_test();
  end
endmodule : tb_uim_core
